// >>> hdl/sync_serial_pkg.sv
package sync_serial_pkg;
	localparam int GPP_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 6;
	localparam int FRAME_W = 16;
	localparam int SERIAL_PINS = 8;
	localparam int CORE_CLK_HZ = 25_000_000;

	localparam logic [ADDR_W-1:0] CTRL_OFS = 6'h00;
	localparam logic [ADDR_W-1:0] BAUD_OFS = 6'h04;
	localparam logic [ADDR_W-1:0] TXB_OFS = 6'h08;
	localparam logic [ADDR_W-1:0] RXB_OFS = 6'h0c;
	localparam logic [ADDR_W-1:0] MODE_OFS = 6'h10;
	localparam logic [ADDR_W-1:0] DIR_OFS = 6'h14;
	localparam logic [ADDR_W-1:0] LATCH_OFS = 6'h18;
	localparam logic [ADDR_W-1:0] PIN_IN_OFS = 6'h1c;

	localparam int CTL_WIDTH_LSB = 0;
	localparam int CTL_WIDTH_W = 4;
	localparam int CTL_MSB_BIT = 4;
	localparam int CTL_PHASE_BIT = 5;
	localparam int CTL_IDLE_BIT = 6;
	localparam int CTL_MASTER_BIT = 8;
	localparam int CTL_EN_BIT = 15;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_TXFULL_BIT = 1;
	localparam int ST_RXFULL_BIT = 2;

	localparam int MODE_W = 3;
	localparam logic [MODE_W-1:0] PF_SERIAL = 3'h3;
	localparam int PIN_MOSI = 0;
	localparam int PIN_MISO = 1;
	localparam int PIN_SCLK = 2;

	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] BAUD_RST = 16'h0001;
	localparam logic [15:0] BAUD_MIN = 16'h0001;
	localparam logic [15:0] LATCH_RST = 16'hffff;
	localparam logic [15:0] DIR_RST = 16'h0000;
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic [3:0] WIDTH_MIN_M1 = 4'h1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOADED = 3'b010,
		ST_RUN = 3'b100
	} xfer_state_e;

	typedef struct packed {
		logic [GPP_W-1:0] out;
		logic [GPP_W-1:0] oe_n;
	} gpp_drive_s;
endpackage

// >>> hdl/sync_serial_port.sv
// Summary of operation
// RL1: Full and half duplex exchange, fast rates
// RL2: Sixteen-bit baud generator clocks master shifting
// RL3: Holding buffers both ways, one shift register
// RL4: Role bit one master, zero slave
// RL5: Field 011 puts lower eight pins serial
// RL6: Software sets pin directions for serial use
// RL7: Control reads config when off, status when on
// RL8: Shift out and in together, equal counts
// RL9: Transmit word loads when shifter empty
// RL10: Master starts at once, slave awaits clock
// RL11: Start sets busy, pulses transmit request
// RL12: Frame done loads receive buffer, pulses request
// RL13: Busy clears with receive load if idle
// RL14: Software leaves busy alone; hardware owns it
// RL15: Only one master on the link
// RL16: Frame width two through sixteen bits
// RL17: Order bit zero LSB first, one MSB
// RL18: Buffers right aligned, shifter reorders bits
// RL19: Bits above width ignored or invalid
// RL20: Phase picks shift edge; latch opposite edge
// RL21: Polarity sets idle clock level
// RL22: Baud from divided core clock, wide range
// RL23: Slave drives first bit on load
`timescale 1ns/1ps
module sync_serial_port (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [sync_serial_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [sync_serial_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [sync_serial_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [sync_serial_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	input wire logic [sync_serial_pkg::GPP_W-1:0] gpp_in,
	output logic [sync_serial_pkg::GPP_W-1:0] gpp_out,
	output logic [sync_serial_pkg::GPP_W-1:0] gpp_oe_n,
	output logic transmit_irq_request,
	output logic receive_irq_request
);
	import sync_serial_pkg::*;

	typedef struct packed {
		xfer_state_e state;
		logic [15:0] ctrl;
		logic [15:0] baud;
		logic [15:0] baud_cnt;
		logic [FRAME_W-1:0] txbuf;
		logic [FRAME_W-1:0] rxbuf;
		logic [FRAME_W-1:0] sr;
		logic txfull;
		logic rxfull;
		logic busy;
		logic rxbit;
		logic [4:0] edge_cnt;
		logic sclk;
		logic mosi;
		logic miso;
		logic sclk_prev;
		logic [MODE_W-1:0] mode;
		logic [GPP_W-1:0] dir;
		logic [GPP_W-1:0] latch;
		gpp_drive_s pins;
		logic tx_irq;
		logic rx_irq;
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] waddr;
		logic [DATA_W-1:0] wdat;
		logic [3:0] wstb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} st_s;

	localparam st_s ST_RST = '{
		state: ST_IDLE,
		ctrl: CTRL_RST,
		baud: BAUD_RST,
		baud_cnt: BAUD_RST,
		sclk: 1'b1,
		mosi: 1'b1,
		miso: 1'b1,
		mode: MODE_RST,
		dir: DIR_RST,
		latch: LATCH_RST,
		pins: '{out: LATCH_RST, oe_n: ~DIR_RST},
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		default: '0
	};

	st_s st_ff;
	st_s nxt_st;

	logic en;
	logic master;
	logic phase;
	logic msb_first;
	logic idle_lvl;
	logic serial_mode;
	logic [3:0] wm1;
	logic [4:0] last_edge;
	logic [4:0] e;
	logic tick;
	logic sclk_in;
	logic data_in;
	logic sclk_chg;
	logic go_edge;
	logic lead;
	logic done;
	logic drive_en;
	logic drive_bit;
	logic alt;
	logic [FRAME_W-1:0] sr_v;
	logic [DATA_W-1:0] merged;
	logic [DATA_W-1:0] cur;

	function automatic logic [FRAME_W-1:0] width_mask(input logic [3:0] m1);
		logic [FRAME_W-1:0] m;
		m = '0;
		for (int i = 0; i < FRAME_W; i++) begin
			m[i] = (i <= int'(m1));
		end
		return m;
	endfunction

	function automatic logic out_bit(input logic [FRAME_W-1:0] sr,
		input logic [3:0] m1, input logic msb);
		return msb ? sr[m1] : sr[0];
	endfunction

	function automatic logic [FRAME_W-1:0] shift_in(
		input logic [FRAME_W-1:0] sr, input logic b,
		input logic [3:0] m1, input logic msb);
		logic [FRAME_W-1:0] r;
		if (msb) begin
			r = {sr[FRAME_W-2:0], b} & width_mask(m1);
		end else begin
			r = {1'b0, sr[FRAME_W-1:1]} & width_mask(m1);
			r[m1] = b;
		end
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nw, input logic [3:0] stb);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (stb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] reg_value(input st_s s,
		input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] v;
		v = '0;
		case (a)
			CTRL_OFS: begin
				if (s.ctrl[CTL_EN_BIT]) begin
					v[CTL_EN_BIT] = 1'b1; // RL7
					v[ST_BUSY_BIT] = s.busy;
					v[ST_TXFULL_BIT] = s.txfull;
					v[ST_RXFULL_BIT] = s.rxfull;
				end else begin
					v[15:0] = s.ctrl; // RL7
				end
			end
			BAUD_OFS: v[15:0] = s.baud;
			TXB_OFS: v[FRAME_W-1:0] = s.txbuf;
			RXB_OFS: v[FRAME_W-1:0] = s.rxbuf;
			MODE_OFS: v[MODE_W-1:0] = s.mode;
			DIR_OFS: v[GPP_W-1:0] = s.dir;
			LATCH_OFS: v[GPP_W-1:0] = s.latch;
			PIN_IN_OFS: v[GPP_W-1:0] = gpp_in;
			default: v = '0;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return a[1:0] == 2'h0 && a <= PIN_IN_OFS;
	endfunction

	always_comb begin
		nxt_st = st_ff;
		sr_v = st_ff.sr;
		e = st_ff.edge_cnt;
		go_edge = 1'b0;
		lead = 1'b0;
		done = 1'b0;
		drive_en = 1'b0;
		drive_bit = 1'b0;
		alt = 1'b1;
		merged = '0;
		cur = '0;
		tick = 1'b0;
		nxt_st.tx_irq = 1'b0;
		nxt_st.rx_irq = 1'b0;
		en = st_ff.ctrl[CTL_EN_BIT];
		master = st_ff.ctrl[CTL_MASTER_BIT]; // RL4
		phase = st_ff.ctrl[CTL_PHASE_BIT];
		msb_first = st_ff.ctrl[CTL_MSB_BIT]; // RL17
		idle_lvl = st_ff.ctrl[CTL_IDLE_BIT];
		serial_mode = st_ff.mode == PF_SERIAL; // RL5
		wm1 = st_ff.ctrl[CTL_WIDTH_LSB +: CTL_WIDTH_W];
		if (wm1 == 4'h0) begin
			wm1 = WIDTH_MIN_M1; // RL16
		end
		last_edge = {wm1, 1'b1};
		sclk_in = gpp_in[PIN_SCLK];
		data_in = master ? gpp_in[PIN_MISO] : gpp_in[PIN_MOSI]; // RL1
		sclk_chg = sclk_in != st_ff.sclk_prev;
		nxt_st.sclk_prev = sclk_in;

		// Read channel; receive flag clear comes before the engine sets it
		if (arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = reg_value(st_ff, araddr);
			nxt_st.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			if (araddr == RXB_OFS) begin
				nxt_st.rxfull = 1'b0;
			end
		end
		if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// Baud generator: half bit every baud+1 cycles, a baud of 0 counts as 1
		if (st_ff.baud_cnt == 16'h0000) begin
			tick = 1'b1; // RL2 RL22
			nxt_st.baud_cnt = (st_ff.baud < BAUD_MIN) ? BAUD_MIN : st_ff.baud;
		end else begin
			nxt_st.baud_cnt = st_ff.baud_cnt - 16'h0001;
		end

		if (!en) begin
			nxt_st.state = ST_IDLE;
			nxt_st.busy = 1'b0;
			nxt_st.sclk = 1'b1;
			nxt_st.mosi = 1'b1;
			nxt_st.miso = 1'b1;
			nxt_st.edge_cnt = 5'h00;
		end else begin
			if (master && st_ff.state != ST_RUN) begin
				nxt_st.sclk = idle_lvl; // RL21
			end
			case (st_ff.state)
				ST_IDLE: begin
					if (!master && !st_ff.txfull && sclk_chg &&
						sclk_in != idle_lvl) begin
						nxt_st.busy = 1'b1;
						go_edge = 1'b1;
						e = 5'h00;
					end
				end
				ST_LOADED: begin
					if (master && tick) begin
						nxt_st.state = ST_RUN; // RL10
						nxt_st.edge_cnt = 5'h00;
						if (!phase) begin
							drive_en = 1'b1;
							drive_bit = out_bit(st_ff.sr, wm1, msb_first);
						end
					end else if (!master && sclk_chg &&
						sclk_in != idle_lvl) begin
						go_edge = 1'b1; // RL10
						e = 5'h00;
					end
				end
				ST_RUN: begin
					go_edge = master ? tick : sclk_chg;
				end
				default: nxt_st.state = ST_IDLE;
			endcase

			if (go_edge) begin
				nxt_st.state = ST_RUN;
				lead = ~e[0];
				if (master) begin
					nxt_st.sclk = ~st_ff.sclk;
				end
				if (!phase) begin
					if (lead) begin
						nxt_st.rxbit = data_in; // RL20
					end else begin
						sr_v = shift_in(st_ff.sr, st_ff.rxbit, wm1,
							msb_first); // RL8 RL18
						drive_en = e != last_edge;
						drive_bit = out_bit(sr_v, wm1, msb_first);
					end
				end else begin
					if (lead) begin
						if (e != 5'h00) begin
							sr_v = shift_in(st_ff.sr, st_ff.rxbit, wm1,
								msb_first); // RL20
						end
						drive_en = 1'b1;
						drive_bit = out_bit(sr_v, wm1, msb_first);
					end else begin
						nxt_st.rxbit = data_in;
						if (e == last_edge) begin
							sr_v = shift_in(st_ff.sr, data_in, wm1,
								msb_first); // RL8
						end
					end
				end
				nxt_st.sr = sr_v;
				nxt_st.edge_cnt = e + 5'h01;
				if (e == last_edge) begin
					done = 1'b1;
					nxt_st.rxbuf = sr_v; // RL12
					nxt_st.rxfull = 1'b1;
					nxt_st.rx_irq = 1'b1;
					nxt_st.state = ST_IDLE;
					nxt_st.busy = 1'b0; // RL13
					nxt_st.edge_cnt = 5'h00;
				end
			end

			if (st_ff.txfull && (st_ff.state == ST_IDLE || done)) begin
				nxt_st.sr = st_ff.txbuf & width_mask(wm1); // RL9 RL19
				nxt_st.txfull = 1'b0;
				nxt_st.tx_irq = 1'b1; // RL11
				nxt_st.busy = 1'b1; // RL11
				nxt_st.state = ST_LOADED;
				nxt_st.edge_cnt = 5'h00;
				if (!master) begin
					drive_en = 1'b1; // RL23
					drive_bit = out_bit(st_ff.txbuf, wm1, msb_first);
				end
			end

			if (drive_en) begin
				if (master) begin
					nxt_st.mosi = drive_bit;
				end else begin
					nxt_st.miso = drive_bit;
				end
			end
		end

		// Write channel; transmit buffer write after the engine so set wins
		if (awvalid && st_ff.awready) begin
			nxt_st.awready = 1'b0;
			nxt_st.aw_held = 1'b1;
			nxt_st.waddr = awaddr;
		end
		if (wvalid && st_ff.wready) begin
			nxt_st.wready = 1'b0;
			nxt_st.w_held = 1'b1;
			nxt_st.wdat = wdata;
			nxt_st.wstb = wstrb;
		end
		if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = mapped(st_ff.waddr) ? RESP_OKAY : RESP_SLVERR;
			cur = reg_value(st_ff, st_ff.waddr);
			if (st_ff.waddr == CTRL_OFS) begin
				cur[15:0] = st_ff.ctrl;
			end
			merged = merge(cur, st_ff.wdat, st_ff.wstb);
			case (st_ff.waddr)
				CTRL_OFS: begin
					if (en) begin
						nxt_st.ctrl[CTL_EN_BIT] = merged[CTL_EN_BIT];
					end else begin
						nxt_st.ctrl = merged[15:0]; // RL14
					end
				end
				BAUD_OFS: nxt_st.baud = merged[15:0];
				TXB_OFS: begin
					nxt_st.txbuf = merged[FRAME_W-1:0]; // RL3
					nxt_st.txfull = 1'b1;
				end
				MODE_OFS: nxt_st.mode = merged[MODE_W-1:0];
				DIR_OFS: nxt_st.dir = merged[GPP_W-1:0];
				LATCH_OFS: nxt_st.latch = merged[GPP_W-1:0];
				default: nxt_st.bresp = st_ff.waddr == RXB_OFS ||
					st_ff.waddr == PIN_IN_OFS ? RESP_OKAY : RESP_SLVERR;
			endcase
		end
		if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
		end

		// Pin mux: serial output ANDed with the port latch
		for (int i = 0; i < GPP_W; i++) begin
			alt = 1'b1;
			if (serial_mode && i < SERIAL_PINS) begin
				if (i == PIN_MOSI) begin
					alt = master ? nxt_st.mosi : 1'b1; // RL5
				end else if (i == PIN_MISO) begin
					alt = master ? 1'b1 : nxt_st.miso;
				end else if (i == PIN_SCLK) begin
					alt = master ? nxt_st.sclk : 1'b1; // RL4
				end
			end
			nxt_st.pins.out[i] = nxt_st.latch[i] & alt;
			nxt_st.pins.oe_n[i] = ~nxt_st.dir[i];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign awready = st_ff.awready;
	assign wready = st_ff.wready;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = st_ff.arready;
	assign rvalid = st_ff.rvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign gpp_out = st_ff.pins.out;
	assign gpp_oe_n = st_ff.pins.oe_n;
	assign transmit_irq_request = st_ff.tx_irq;
	assign receive_irq_request = st_ff.rx_irq;
endmodule

// >>> tb/spi_peer.sv
`timescale 1ns/1ps
module spi_peer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic arm,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [15:0] word,
	output logic miso,
	output logic [15:0] got
);
	logic prev_ff;
	logic [3:0] cnt_ff;
	logic moved;
	logic latch_edge;
	assign moved = sclk != prev_ff;
	// Leading edge leaves the idle level
	assign latch_edge = (prev_ff == cpol) ^ cpha;
	assign miso = word[4'hf - (cnt_ff - {3'h0, cpha})];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_ff <= 1'b0;
			cnt_ff <= 4'h0;
			got <= 16'h0;
		end else begin
			prev_ff <= sclk;
			if (arm) cnt_ff <= 4'h0;
			else if (moved && !latch_edge) cnt_ff <= cnt_ff + 4'h1;
			if (moved && latch_edge) got <= {got[14:0], mosi};
		end
	end
endmodule

// >>> tb/sync_serial_port_props.sv
`timescale 1ns/1ps
module sync_serial_port_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic transmit_irq_request,
	input wire logic receive_irq_request
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic open_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) open_ff <= 1'b0;
		else if (transmit_irq_request) open_ff <= 1'b1;
		else if (receive_irq_request) open_ff <= 1'b0;
	end
	sequence s_wr;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_b_ans;
		!awready && !wready ##1 bvalid;
	endsequence
	property p_wr_ans;
		s_wr |=> s_b_ans;
	endproperty
	a_wr_ans: assert property (p_wr_ans)
		else $error("write answer late");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_b_done;
		bvalid && bready |=> !bvalid && awready && wready;
	endproperty
	a_b_done: assert property (p_b_done)
		else $error("write channel not freed");
	property p_rd_ans;
		arvalid && arready |=> rvalid && !arready;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read answer late");
	property p_tx_pulse;
		transmit_irq_request |=> !transmit_irq_request;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse)
		else $error("transmit request too long");
	property p_rx_pulse;
		receive_irq_request |=> !receive_irq_request;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse)
		else $error("receive request too long");
	property p_rx_open;
		receive_irq_request |-> open_ff;
	endproperty
	a_rx_open: assert property (p_rx_open)
		else $error("receive without a started frame");
	property p_tx_empty;
		transmit_irq_request && !receive_irq_request |-> !open_ff;
	endproperty
	a_tx_empty: assert property (p_tx_empty)
		else $error("load while shifter busy");
endmodule
bind sync_serial_port sync_serial_port_chk i_chk (.core_clk(core_clk),
	.rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.transmit_irq_request(transmit_irq_request),
	.receive_irq_request(receive_irq_request));

// >>> tb/sync_serial_port_tb.sv
`timescale 1ns/1ps
module sync_serial_port_tb;
	import sync_serial_pkg::*;
	logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready, arm;
	logic awready, wready, bvalid, arready, rvalid, tirq, rirq, miso;
	logic cpol, cpha;
	logic [3:0] wstrb;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, rdv;
	logic [1:0] bresp, rresp, rrs;
	logic [15:0] gpp_out, gpp_oe_n, ext, pad, mword, got;
	int num_errors, cmp_count;
	int n_tx = 0;
	int n_rx = 0;
	assign pad = ~gpp_oe_n & gpp_out | gpp_oe_n & {ext[15:2], miso, ext[0]};
	sync_serial_port i_dut (.core_clk(core_clk), .rst(rst),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.gpp_in(pad), .gpp_out(gpp_out), .gpp_oe_n(gpp_oe_n),
		.transmit_irq_request(tirq), .receive_irq_request(rirq));
	spi_peer i_peer (.core_clk(core_clk), .rst(rst), .arm(arm),
		.sclk(pad[PIN_SCLK]), .mosi(pad[PIN_MOSI]), .cpol(cpol),
		.cpha(cpha), .word(mword), .miso(miso), .got(got));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (tirq === 1'b1) n_tx <= n_tx + 1;
		if (rirq === 1'b1) n_rx <= n_rx + 1;
	end
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tmo;
		num_errors++;
		tally_and_finish();
	endtask
	task automatic bus(input logic w, input logic [5:0] a, logic [31:0] d);
		int i;
		if (w) {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
		else {arvalid, rready, araddr} <= {2'h3, a};
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if (bvalid || rvalid) break;
		end
		{bready, rready} <= 2'h0;
		rdv = rdata;
		rrs = w ? bresp : rresp;
		if (i == 50) tmo();
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		chk(rrs, RESP_OKAY);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask
	task automatic wait_rx(input int n);
		int i;
		for (i = 0; i < 3000 && n_rx < n; i++) @(posedge core_clk);
		if (i == 3000) tmo();
	endtask
	task automatic t_regs;
		rdc(CTRL_OFS, 32'(CTRL_RST));
		rdc(BAUD_OFS, 32'(BAUD_RST));
		rdc(LATCH_OFS, 32'(LATCH_RST));
		rdc(DIR_OFS, 32'(DIR_RST));
		rdc(MODE_OFS, 32'(MODE_RST));
		bus(1'b0, 6'h20, 32'h0);
		chk(rdv, 32'h0);
		chk(rrs, RESP_SLVERR);
		wr(CTRL_OFS, 32'h017f);
		rdc(CTRL_OFS, 32'h017f);
		wr(CTRL_OFS, 32'h817f);
		rdc(CTRL_OFS, 32'h8000);
		wr(CTRL_OFS, 32'h8001);
		rdc(CTRL_OFS, 32'h8000);
		wr(CTRL_OFS, 32'h0);
		ext <= 16'ha500;
		wr(MODE_OFS, 32'(PF_SERIAL));
		bus(1'b0, PIN_IN_OFS, 32'h0);
		chk(rdv[15:8], 8'ha5);
		wr(DIR_OFS, 32'hff00);
		wr(LATCH_OFS, 32'h3cff);
		chk({gpp_oe_n[15:8], gpp_out[15:8]}, 16'h003c);
		$display("register test done");
	endtask
	task automatic t_master(input int w, input logic msb, ph, po,
		input logic [15:0] baud, tx, word);
		int i, t, n;
		logic [15:0] e, g;
		{e, g} = 32'h0;
		for (i = 0; i < w; i++) begin
			e[msb ? w - 1 - i : i] = word[15 - i];
			g[msb ? i : w - 1 - i] = tx[i];
		end
		{cpol, cpha, mword} <= {po, ph, word};
		wr(BAUD_OFS, 32'(baud));
		wr(DIR_OFS, 32'hff05);
		wr(CTRL_OFS, 32'h8100 | {po, ph, msb, 4'(w - 1)});
		arm <= 1'b1;
		@(posedge core_clk);
		arm <= 1'b0;
		n = n_rx;
		wr(TXB_OFS, 32'(tx));
		for (t = 0; t < 99 && pad[PIN_SCLK] === po; t++) @(posedge core_clk);
		if (t == 99) tmo();
		for (t = 0; t < 99 && pad[PIN_SCLK] !== po; t++) @(posedge core_clk);
		if (t == 99) tmo();
		chk(t, baud + 1);
		wait_rx(n + 1);
		chk(pad[PIN_SCLK], po);
		rdc(CTRL_OFS, 32'h8004);
		rdc(RXB_OFS, 32'(e));
		chk(got & (16'hffff >> (16 - w)), g);
		wr(CTRL_OFS, 32'h0);
		$display("master test done");
	endtask
	task automatic t_b2b;
		int t, n;
		wr(CTRL_OFS, 32'h8103);
		t = n_tx;
		n = n_rx;
		wr(TXB_OFS, 32'h5);
		wr(TXB_OFS, 32'ha);
		rdc(CTRL_OFS, 32'h8003);
		wait_rx(n + 2);
		chk(n_tx - t, 2);
		rdc(CTRL_OFS, 32'h8004);
		wr(CTRL_OFS, 32'h0);
		$display("reload test done");
	endtask
	task automatic t_slave;
		int i, t, n;
		wr(DIR_OFS, 32'hff02);
		wr(CTRL_OFS, 32'h8013);
		t = n_tx;
		n = n_rx;
		wr(TXB_OFS, 32'h5);
		repeat (20) @(posedge core_clk);
		chk(n_tx - t, 1);
		chk(n_rx - n, 0);
		chk(pad[PIN_MISO], 1'b0);
		for (i = 3; i >= 0; i--) begin
			// Sends 0110, expects 0101 back
			ext[PIN_MOSI] <= i[1] ^ i[0];
			repeat (3) @(posedge core_clk);
			chk(pad[PIN_MISO], !i[0]);
			ext[PIN_SCLK] <= 1'b1;
			repeat (3) @(posedge core_clk);
			ext[PIN_SCLK] <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
		wait_rx(n + 1);
		rdc(RXB_OFS, 32'h6);
		wr(CTRL_OFS, 32'h0);
		$display("slave test done");
	endtask
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, arm, cpol, cpha} = 8'h0;
		{awaddr, araddr, wdata, ext, mword} = '0;
		wstrb = 4'hf;
		{num_errors, cmp_count} = '0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_regs();
		t_master(2, 1'b1, 1'b0, 1'b0, 16'h1, 16'hfffe, 16'h8000);
		t_master(16, 1'b0, 1'b1, 1'b0, 16'h2, 16'h1234, 16'hc3a5);
		t_master(5, 1'b1, 1'b1, 1'b1, 16'h1, 16'hffd3, 16'h5a00);
		t_master(8, 1'b0, 1'b0, 1'b1, 16'h3, 16'hab5c, 16'h9600);
		t_b2b();
		t_slave();
		tally_and_finish();
	end
endmodule
